// ==== shared/sbd_pkg.sv ====
// Constants, types and value conversions shared by the sixteen-bit ALU datapath.
package sbd_pkg;
    // Operation codes presented on the command port.
    typedef enum logic [3:0] {
        OP_LOAD = 4'h0, OP_RDP = 4'h1, OP_RDE = 4'h2, OP_RDPAIR = 4'h3,
        OP_RDF1 = 4'h4, OP_RDF2 = 4'h5, OP_RDR = 4'h6, OP_RDR48 = 4'h7,
        OP_IMM = 4'h8, OP_ADC = 4'h9, OP_SBC = 4'hA, OP_RND = 4'hB,
        OP_AND = 4'hC, OP_ROL = 4'hD, OP_DUAL_MAC_OP = 4'hE, OP_BIT = 4'hF
    } sbd_op_t;
    // Register targets: accumulator words first, then the input words.
    typedef enum logic [2:0] {
        DST_LOW = 3'h0, DST_HIGH = 3'h1, DST_EXT = 3'h2, DST_FULL = 3'h3,
        DST_X0 = 3'h4, DST_X1 = 3'h5, DST_Y0 = 3'h6, DST_Y1 = 3'h7
    } sbd_dst_t;
    // Scaling modes; code 3 behaves as no scaling.
    localparam logic [1:0] SCL_DOWN = 2'h1;
    localparam logic [1:0] SCL_UP = 2'h2;
    // Bit sub-operations.
    localparam logic [1:0] BIT_TST = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_CLR = 2'h2;
    // Limiter clamp values.
    localparam logic [23:0] LIM16_POS = 24'h007FFF;
    localparam logic [23:0] LIM16_NEG = 24'h008000;
    localparam logic [23:0] LIM16_DY_POS = 24'h00FFFF;
    localparam logic [23:0] LIM24_POS = 24'h7FFFFF;
    localparam logic [23:0] LIM24_NEG = 24'h800000;
    localparam logic [23:0] LIM24_DY_POS = 24'hFFFFFF;
    localparam logic [23:0] LIM_DY_NEG = 24'h000000;
    // Arithmetic saturation values.
    localparam logic [55:0] SAT16_POS = 56'h007FFF00FFFF00;
    localparam logic [55:0] SAT24_POS = 56'h007FFFFFFFFFFF;
    localparam logic [55:0] SAT_NEG = 56'hFF800000000000;
    // Bit positions and shift counts.
    localparam logic [5:0] RND16_POS = 6'h0F;
    localparam logic [5:0] RND24_POS = 6'h17;
    localparam logic [5:0] DUAL_MAC_OP_SH16 = 6'h10;
    localparam logic [5:0] DUAL_MAC_OP_SH24 = 6'h18;
    localparam logic [4:0] BIT16_MAX = 5'h0F;
    localparam logic [4:0] BIT24_MAX = 5'h17;
    localparam logic [4:0] BIT16_OFS = 5'h08;

    // Accumulator to a linear signed value; sixteen-bit mode joins the portions.
    function automatic logic [55:0] to_lin(input logic [55:0] a, input logic m16);
        to_lin = m16 ? {{16{a[55]}}, a[55:32], a[23:8]} : a;
    endfunction : to_lin

    // Linear value back to accumulator layout; sixteen-bit mode forces the low bytes to zero.
    function automatic logic [55:0] from_lin(input logic [55:0] v, input logic m16);
        from_lin = m16 ? {v[39:16], 8'h00, v[15:0], 8'h00} : v;
    endfunction : from_lin
endpackage : sbd_pkg

// ==== shared/sbd_lim_if.sv ====
// Carrier between the datapath and its scaling and limiting unit.
interface sbd_lim_if;
    logic [55:0] acc;
    logic [1:0] scale;
    logic m16;
    logic [23:0] word;
    logic [23:0] dx;
    logic [23:0] dy;
    logic limited;
    modport client (output acc, scale, m16, input word, dx, dy, limited);
    modport lim (input acc, scale, m16, output word, dx, dy, limited);
endinterface : sbd_lim_if

// ==== verilog/sbd_limiter.sv ====
// Scaling and limiting of a full accumulator read onto the data buses.
module sbd_limiter
    import sbd_pkg::*;
(
    sbd_lim_if.lim lim_io
);
    logic [55:0] lin;
    logic [55:0] scl;
    logic ovf;
    logic neg;

    // The shifter sees lower and upper portion as one number.
    assign lin = to_lin(lim_io.acc, lim_io.m16);
    assign scl = (lim_io.scale == SCL_DOWN) ? 56'($signed(lin) >>> 1) :
                 (lim_io.scale == SCL_UP) ? {lin[54:0], 1'b0} : lin;
    assign neg = scl[55];
    // Overflow when the extension is not a copy of the upper portion's sign.
    assign ovf = lim_io.m16 ? !(&scl[55:31] || !(|scl[55:31])) :
                              !(&scl[55:47] || !(|scl[55:47]));
    assign lim_io.limited = ovf;

    // Clamp values follow the mode's word width.
    assign lim_io.word = lim_io.m16 ?
        (ovf ? (neg ? LIM16_NEG : LIM16_POS) : {{8{scl[31]}}, scl[31:16]}) :
        (ovf ? (neg ? LIM24_NEG : LIM24_POS) : scl[47:24]);
    assign lim_io.dx = lim_io.word;
    assign lim_io.dy = lim_io.m16 ?
        (ovf ? (neg ? LIM_DY_NEG : LIM16_DY_POS) : {8'h00, scl[15:0]}) :
        (ovf ? (neg ? LIM_DY_NEG : LIM24_DY_POS) : scl[23:0]);
endmodule : sbd_limiter

// ==== verilog/sbd_alu.sv ====
// Data ALU datapath with sixteen-bit arithmetic mode: bus placement, immediates, arithmetic.
module sbd_alu
    import sbd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic sixteen_bit_mode_bit,
    input wire logic [1:0] scale_mode,
    input wire logic sat_mode,
    input wire logic dp_mode,
    input wire logic carry_in,
    input wire logic cmd_valid,
    input wire sbd_op_t cmd_op,
    input wire sbd_dst_t cmd_dst,
    input wire logic cmd_acc,
    input wire logic cmd_xy,
    input wire logic [4:0] cmd_bit,
    input wire logic [1:0] cmd_sub,
    input wire logic [23:0] cmd_data,
    output logic [23:0] x_data_bus_r,
    output logic [23:0] y_data_bus_r,
    output logic bus_valid_r,
    output logic limit_hit_r,
    output logic bit_result_r,
    output logic bit_range_err_r,
    output logic carry_out_r,
    output logic [55:0] acc_a_r,
    output logic [55:0] acc_b_r
);
    // ************************************************************
    // Helpers
    // ************************************************************

    // Upper sixteen bits of a word, right-aligned with a zero top byte.
    function automatic logic [23:0] w16(input logic [23:0] v);
        w16 = {8'h00, v[23:8]};
    endfunction : w16

    // Extension not a copy of the top data bit: saturation must act.
    function automatic logic ovf_chk(input logic [55:0] v, input logic m16);
        ovf_chk = m16 ? !(&v[55:31] || !(|v[55:31])) :
                        !(&v[55:47] || !(|v[55:47]));
    endfunction : ovf_chk

    // ************************************************************
    // Storage and operand selection
    // ************************************************************

    logic [23:0] in_r [0:3];
    logic [55:0] acc_nxt;
    logic [23:0] reg_nxt;
    logic m16;
    logic [55:0] acc_sel;
    logic [23:0] part_w;
    logic [7:0] ext_w;
    logic [23:0] hi_w;
    logic [23:0] lo_w;
    logic [23:0] reg_w;
    logic [23:0] pair_hi;
    logic [23:0] pair_lo;

    // The mode bit comes from the status register on this clock.
    assign m16 = sixteen_bit_mode_bit;
    assign acc_sel = cmd_acc ? acc_b_r : acc_a_r;
    assign hi_w = acc_sel[47:24];
    assign lo_w = acc_sel[23:0];
    assign ext_w = acc_sel[55:48];
    assign part_w = (cmd_dst == DST_LOW) ? lo_w : hi_w;
    assign reg_w = in_r[cmd_dst[1:0]];
    assign pair_hi = in_r[{cmd_xy, 1'b1}];
    assign pair_lo = in_r[{cmd_xy, 1'b0}];

    // ************************************************************
    // Bus placement
    // ************************************************************

    sbd_lim_if lim_bus();
    sbd_limiter u_lim (
        .lim_io(lim_bus)
    );
    assign lim_bus.acc = acc_sel;
    assign lim_bus.scale = scale_mode;
    assign lim_bus.m16 = m16;

    logic [23:0] rdp_v;
    logic [23:0] rde_v;
    logic [23:0] pair_x;
    logic [23:0] pair_y;
    logic [23:0] rdr_v;
    logic [23:0] r48_x;
    logic [23:0] r48_y;
    logic [23:0] one_v;
    logic one_bus;
    logic two_bus;
    logic [23:0] x_nxt;
    logic [23:0] y_nxt;

    // Word views per source; mode clear passes the full word.
    assign rdp_v = m16 ? w16(part_w) : part_w;
    assign rde_v = {{16{ext_w[7]}}, ext_w};
    assign pair_x = m16 ? w16(hi_w) : hi_w;
    assign pair_y = m16 ? w16(lo_w) : lo_w;
    assign rdr_v = m16 ? w16(reg_w) : reg_w;
    assign r48_x = m16 ? w16(pair_hi) : pair_hi;
    // The low input word gives its low sixteen bits here, as the device does.
    assign r48_y = m16 ? {8'h00, pair_lo[15:0]} : pair_lo;

    // Single-bus reads go to the bus named by cmd_xy; the other bus reads zero.
    assign one_bus = cmd_valid && (cmd_op == OP_RDP || cmd_op == OP_RDE ||
                                   cmd_op == OP_RDF1 || cmd_op == OP_RDR);
    assign two_bus = cmd_valid && (cmd_op == OP_RDPAIR || cmd_op == OP_RDF2 ||
                                   cmd_op == OP_RDR48);
    assign one_v = (cmd_op == OP_RDP) ? rdp_v :
                   (cmd_op == OP_RDE) ? rde_v :
                   (cmd_op == OP_RDF1) ? lim_bus.word : rdr_v;
    assign x_nxt = one_bus ? (cmd_xy ? 24'h000000 : one_v) :
                   (cmd_op == OP_RDPAIR) ? pair_x :
                   (cmd_op == OP_RDF2) ? lim_bus.dx : r48_x;
    assign y_nxt = one_bus ? (cmd_xy ? one_v : 24'h000000) :
                   (cmd_op == OP_RDPAIR) ? pair_y :
                   (cmd_op == OP_RDF2) ? lim_bus.dy : r48_y;

    // Bus words hold until the next read; the top byte right after a
    // same-register write may differ on real silicon, so this copy is
    // simply the clean value.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            x_data_bus_r <= 24'h000000;
            y_data_bus_r <= 24'h000000;
            bus_valid_r <= 1'b0;
            limit_hit_r <= 1'b0;
        end else begin
            bus_valid_r <= one_bus || two_bus;
            if (one_bus || two_bus) begin
                x_data_bus_r <= x_nxt;
                y_data_bus_r <= y_nxt;
                limit_hit_r <= (cmd_op == OP_RDF1 || cmd_op == OP_RDF2) && lim_bus.limited;
            end
        end
    end

    // ************************************************************
    // Arithmetic in the linear domain
    // ************************************************************

    logic [55:0] acc_lin;
    logic [55:0] opd_lin;
    logic [55:0] cin_lin;
    logic [55:0] adc_v;
    logic [55:0] sbc_v;
    logic [5:0] rpos;
    logic [55:0] rnd_mask;
    logic [55:0] rnd_v;
    logic [23:0] mul_b;
    logic signed [31:0] p16;
    logic signed [47:0] p24;
    logic [47:0] pu;
    logic dp_eff;
    logic [55:0] prod_lin;
    logic [55:0] dual_mac_op_v;
    logic [55:0] ar_lin;
    logic [55:0] ar_acc;
    logic [55:0] and_acc;
    logic [55:0] rol_acc;
    logic [55:0] arith_acc;
    logic is_arith;

    // Operands join into one number, losing their low byte in sixteen-bit mode.
    assign acc_lin = to_lin(acc_sel, m16);
    assign opd_lin = m16 ? {{24{pair_hi[23]}}, pair_hi[23:8], pair_lo[23:8]} :
                           {{8{pair_hi[23]}}, pair_hi, pair_lo};
    // Carry lands on the least significant bit of the lower portion.
    assign cin_lin = {55'h0, carry_in};
    assign adc_v = acc_lin + opd_lin + cin_lin;
    assign sbc_v = acc_lin - opd_lin - cin_lin;

    // Round at the lower portion's top bit, moved by one for scaling.
    assign rpos = ((m16 ? RND16_POS : RND24_POS) +
                   ((scale_mode == SCL_DOWN) ? 6'h01 : 6'h00)) -
                  ((scale_mode == SCL_UP) ? 6'h01 : 6'h00);
    assign rnd_mask = (56'h1 << (rpos + 6'h01)) - 56'h1;
    assign rnd_v = (acc_lin + (56'h1 << rpos)) & ~rnd_mask;

    // Product of the chosen input word and its partner in the other pair.
    assign mul_b = in_r[cmd_dst[1:0] ^ 2'h2];
    assign p16 = $signed(reg_w[23:8]) * $signed(mul_b[23:8]);
    assign p24 = $signed(reg_w) * $signed(mul_b);
    assign pu = reg_w * mul_b;
    // The double-precision multiply is ignored in sixteen-bit mode.
    assign dp_eff = dp_mode && !m16;
    assign prod_lin = m16 ? {{23{p16[31]}}, p16, 1'b0} :
                      dp_eff ? {8'h00, pu} : {{7{p24[47]}}, p24, 1'b0};
    // Accumulator shifts right by a portion before accumulating.
    assign dual_mac_op_v = 56'($signed(acc_lin) >>> (m16 ? DUAL_MAC_OP_SH16 : DUAL_MAC_OP_SH24)) + prod_lin;

    assign ar_lin = (cmd_op == OP_ADC) ? adc_v :
                    (cmd_op == OP_SBC) ? sbc_v :
                    (cmd_op == OP_RND) ? rnd_v : dual_mac_op_v;
    // Detection and the positive limit follow the mode; the negative limit is shared.
    assign ar_acc = (sat_mode && ovf_chk(ar_lin, m16)) ?
                    (ar_lin[55] ? SAT_NEG : (m16 ? SAT16_POS : SAT24_POS)) :
                    from_lin(ar_lin, m16);

    // Logic and rotate work on a sixteen-bit word in this mode.
    assign and_acc = m16 ? {acc_sel[55:48], hi_w[23:8] & reg_w[23:8], 8'h00,
                            lo_w[23:8], 8'h00} :
                           {acc_sel[55:48], hi_w & reg_w, lo_w};
    assign rol_acc = m16 ? {acc_sel[55:48], hi_w[22:8], carry_in, 8'h00,
                            lo_w[23:8], 8'h00} :
                           {acc_sel[55:48], hi_w[22:0], carry_in, lo_w};
    assign is_arith = cmd_valid && (cmd_op == OP_ADC || cmd_op == OP_SBC ||
                                    cmd_op == OP_RND || cmd_op == OP_AND ||
                                    cmd_op == OP_ROL || cmd_op == OP_DUAL_MAC_OP);
    assign arith_acc = (cmd_op == OP_AND) ? and_acc :
                       (cmd_op == OP_ROL) ? rol_acc : ar_acc;

    // ************************************************************
    // Word writes: raw load, short immediate, bit operations
    // ************************************************************

    logic [7:0] imm;
    logic [23:0] imm_word;
    logic [55:0] imm_full;
    logic [23:0] word_old;
    logic [4:0] bpos;
    logic bit_err;
    logic [23:0] bit_word;
    logic [23:0] word_new;
    logic [55:0] full_new;
    logic [55:0] acc_put;
    logic is_word;
    logic acc_we;
    logic reg_we;

    assign imm = cmd_data[7:0];
    // Short immediates: integer in the partial word, fraction at the top.
    assign imm_word = cmd_dst[2] ? {imm, 16'h0000} :
                      (cmd_dst == DST_EXT) ? {16'h0000, imm} :
                      m16 ? {8'h00, imm, 8'h00} : {16'h0000, imm};
    assign imm_full = {{8{imm[7]}}, imm, 40'h0};
    assign word_old = cmd_dst[2] ? reg_w : (cmd_dst == DST_LOW) ? lo_w :
                      (cmd_dst == DST_EXT) ? {16'h0000, ext_w} : hi_w;

    // Bit numbers count inside the sixteen-bit word in this mode, the full word otherwise; larger ones are refused.
    assign bit_err = m16 ? (cmd_bit > BIT16_MAX) : (cmd_bit > BIT24_MAX);
    assign bpos = m16 ? 5'(cmd_bit + BIT16_OFS) : cmd_bit;
    assign bit_word = (cmd_sub == BIT_SET) ? (word_old | (24'h1 << bpos)) :
                      (cmd_sub == BIT_CLR) ? (word_old & ~(24'h1 << bpos)) :
                      (word_old ^ (24'h1 << bpos));

    assign word_new = (cmd_op == OP_LOAD) ? cmd_data :
                      (cmd_op == OP_IMM) ? imm_word : bit_word;
    assign full_new = (cmd_op == OP_LOAD) ? {{8{cmd_data[23]}}, cmd_data, 24'h0} : imm_full;
    assign acc_put = (cmd_dst == DST_LOW) ? {acc_sel[55:24], word_new} :
                     (cmd_dst == DST_EXT) ? {word_new[7:0], acc_sel[47:0]} :
                     (cmd_dst == DST_FULL && cmd_op != OP_BIT) ? full_new :
                     {acc_sel[55:48], word_new, lo_w};
    assign is_word = cmd_valid && (cmd_op == OP_LOAD || cmd_op == OP_IMM ||
                     (cmd_op == OP_BIT && cmd_sub != BIT_TST && !bit_err));
    assign acc_we = is_arith || (is_word && !cmd_dst[2]);
    assign reg_we = is_word && cmd_dst[2];
    assign acc_nxt = is_arith ? arith_acc : acc_put;
    assign reg_nxt = word_new;

    // Accumulators.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc_a_r <= 56'h0;
            acc_b_r <= 56'h0;
        end else if (acc_we) begin
            if (cmd_acc) begin
                acc_b_r <= acc_nxt;
            end else begin
                acc_a_r <= acc_nxt;
            end
        end
    end

    // Input words.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                in_r[i] <= 24'h000000;
            end
        end else if (reg_we) begin
            in_r[cmd_dst[1:0]] <= reg_nxt;
        end
    end

    // Flags from bit operations and rotates.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bit_result_r <= 1'b0;
            bit_range_err_r <= 1'b0;
            carry_out_r <= 1'b0;
        end else if (cmd_valid) begin
            if (cmd_op == OP_BIT) begin
                bit_result_r <= !bit_err && word_old[bpos];
                bit_range_err_r <= bit_err;
            end
            if (cmd_op == OP_ROL) begin
                carry_out_r <= hi_w[23];
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic rd1x;
    assign rd1x = cmd_valid && m16 && !cmd_xy;

    a_part_read: assert property (rd1x && cmd_op == OP_RDP |=>
        x_data_bus_r == {8'h00, $past(part_w[23:8])} && y_data_bus_r == 24'h0)
        else $error("partial word read misplaced");
    a_ext_read: assert property (cmd_valid && !cmd_xy && cmd_op == OP_RDE |=>
        x_data_bus_r[7:0] == $past(ext_w) && x_data_bus_r[23:8] == {16{x_data_bus_r[7]}})
        else $error("extension read not sign filled");
    a_pair_read: assert property (cmd_valid && m16 && cmd_op == OP_RDPAIR |=>
        x_data_bus_r == w16($past(hi_w)) && y_data_bus_r == w16($past(lo_w)))
        else $error("pair read misplaced");
    a_full_sign: assert property (rd1x && cmd_op == OP_RDF1 |=> bus_valid_r &&
        (x_data_bus_r[23:16] == {8{x_data_bus_r[15]}} || x_data_bus_r == LIM16_NEG))
        else $error("full read not sign extended");
    a_dbl_ytop: assert property (cmd_valid && m16 && cmd_op == OP_RDF2 |=>
        y_data_bus_r[23:16] == 8'h00 && (limit_hit_r || x_data_bus_r[23:16] == {8{x_data_bus_r[15]}}))
        else $error("double read top bytes wrong");
    a_reg_read: assert property (rd1x && cmd_op == OP_RDR |=>
        x_data_bus_r == {8'h00, $past(reg_w[23:8])})
        else $error("input word read misplaced");
    a_imm_part: assert property (cmd_valid && m16 && !cmd_acc && cmd_op == OP_IMM &&
        cmd_dst == DST_HIGH |=> acc_a_r[47:24] == {8'h00, $past(imm), 8'h00})
        else $error("short immediate not at bits 15-8");
    a_imm_full: assert property (cmd_valid && !cmd_acc && cmd_op == OP_IMM &&
        cmd_dst == DST_FULL |=> acc_a_r[47:40] == $past(imm) && acc_a_r[39:0] == 40'h0)
        else $error("short immediate fraction misplaced");
    a_low_zero: assert property (is_arith && m16 && !cmd_acc |=>
        acc_a_r[7:0] == 8'h00 && acc_a_r[31:24] == 8'h00)
        else $error("low bytes not forced to zero");
    a_rnd_clear: assert property (cmd_valid && m16 && !cmd_acc && cmd_op == OP_RND &&
        scale_mode == 2'h0 && !sat_mode |=> acc_a_r[23:8] == 16'h0)
        else $error("rounding left lower portion");
    a_bit_range: assert property (cmd_valid && m16 && cmd_op == OP_BIT && cmd_bit > 5'h0F |=>
        bit_range_err_r && !bit_result_r && $stable(acc_a_r) && $stable(acc_b_r))
        else $error("bit number above 15 accepted");
    a_normal_reg: assert property (cmd_valid && !m16 && !cmd_xy && cmd_op == OP_RDR |=>
        x_data_bus_r == $past(reg_w))
        else $error("normal mode read altered");

    c_full_limit: cover property (cmd_valid && m16 && cmd_op == OP_RDF2 ##1 limit_hit_r);
    c_dmac16: cover property (cmd_valid && m16 && cmd_op == OP_DUAL_MAC_OP);
    c_bit_set: cover property (cmd_valid && m16 && cmd_op == OP_BIT && cmd_sub == BIT_SET);
endmodule : sbd_alu

// ==== test/sbd_bus_sink.sv ====
// Model of the core data buses that take words read out of the datapath.
module sbd_bus_sink (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic bus_valid_r,
    input wire logic [23:0] x_data_bus_r,
    input wire logic [23:0] y_data_bus_r,
    output logic [23:0] got_x,
    output logic [23:0] got_y
);
    timeunit 1ns;
    timeprecision 1ps;
    // Latch only on the valid pulse, since the bus words are stale outside it.
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            got_x <= 24'h000000;
            got_y <= 24'h000000;
        end else if (bus_valid_r) begin
            got_x <= x_data_bus_r;
            got_y <= y_data_bus_r;
        end
    end
endmodule : sbd_bus_sink

// ==== test/tb_sbd_alu.sv ====
// Self-checking bench for the sixteen-bit ALU datapath.
module tb_sbd_alu
    import sbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, reset = 1, m16 = 1, cv = 0, acc = 0, xy = 0, sat = 0, dpm = 0, cin = 0;
    logic [1:0] scl = 0, sub = 0;
    logic [4:0] bn = 0;
    logic [23:0] dat = 0, xb, yb, px, py, r1, r2, r3;
    sbd_op_t op = OP_LOAD;
    sbd_dst_t dst = DST_LOW;
    logic bv, lh, br, be, co;
    logic [55:0] aa, ab;
    logic [31:0] lf = 32'h7056;
    int fails = 0, tests_run = 0;
    always #5 clk_sys = ~clk_sys;
    sbd_alu DUT (.clk_sys(clk_sys), .reset(reset), .sixteen_bit_mode_bit(m16), .scale_mode(scl),
        .sat_mode(sat), .dp_mode(dpm), .carry_in(cin), .cmd_valid(cv), .cmd_op(op), .cmd_dst(dst),
        .cmd_acc(acc), .cmd_xy(xy), .cmd_bit(bn), .cmd_sub(sub), .cmd_data(dat), .x_data_bus_r(xb),
        .y_data_bus_r(yb), .bus_valid_r(bv), .limit_hit_r(lh), .bit_result_r(br), .bit_range_err_r(be),
        .carry_out_r(co), .acc_a_r(aa), .acc_b_r(ab));
    sbd_bus_sink sink (.clk_sys(clk_sys), .reset(reset), .bus_valid_r(bv), .x_data_bus_r(xb),
        .y_data_bus_r(yb), .got_x(px), .got_y(py));
    // A maximal-length feedback register keeps the random words repeatable.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Upper sixteen bits right aligned with a zero top byte.
    function automatic logic [23:0] pz(input logic [23:0] w);
        pz = {8'h00, w[23:8]};
    endfunction : pz
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // One command strobe; the idle cycle after it keeps reads clear of same-register writes.
    task automatic cmd(input sbd_op_t o, input sbd_dst_t d, input logic [23:0] v, input logic s);
        @(posedge clk_sys);
        #1 cv = 1;
        op = o;
        dst = d;
        dat = v;
        xy = s;
        @(posedge clk_sys);
        #1 cv = 0;
    endtask : cmd
    task automatic rd(input sbd_op_t o, input sbd_dst_t d, input logic s);
        cmd(o, d, 24'h000000, s);
        @(posedge clk_sys);
        #1;
    endtask : rd
    // Full read: single word on x, then the double word on both buses.
    task automatic full(input logic [23:0] v, input logic [7:0] e, input logic [1:0] s,
            input logic [23:0] ex, input logic [23:0] ey, input logic l);
        cmd(OP_LOAD, DST_FULL, v, 0);
        cmd(OP_LOAD, DST_EXT, {16'h0000, e}, 0);
        scl = s;
        rd(OP_RDF1, DST_FULL, 0);
        chk(px, ex);
        chk(lh, l);
        rd(OP_RDF2, DST_FULL, 0);
        chk({px, py}, {ex, ey});
        scl = 0;
    endtask : full
    initial begin
        #200us;
        fails++;
        close_out();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 reset = 0;
        chk({aa, xb}, 80'h0);
        for (int i = 0; i < 4; i++) begin
            r1 = lf[23:0];
            lf = lfsr(lf);
            r2 = lf[23:0];
            lf = lfsr(lf);
            r3 = lf[23:0];
            lf = lfsr(lf);
            acc = i[0];
            cmd(OP_LOAD, DST_HIGH, r1, 0);
            cmd(OP_LOAD, DST_LOW, r2, 0);
            cmd(OP_LOAD, DST_EXT, r3, 0);
            rd(OP_RDP, DST_HIGH, 0);
            chk({px, py}, {pz(r1), 24'h0});
            rd(OP_RDP, DST_LOW, 1);
            chk({px, py}, {24'h0, pz(r2)});
            rd(OP_RDE, DST_EXT, 0);
            chk(px, {{16{r3[7]}}, r3[7:0]});
            rd(OP_RDPAIR, DST_LOW, 0);
            chk({px, py}, {pz(r1), pz(r2)});
            cmd(OP_LOAD, DST_X1, r1, 0);
            cmd(OP_LOAD, DST_X0, r2, 0);
            rd(OP_RDR, DST_X1, 0);
            chk(px, pz(r1));
            rd(OP_RDR48, DST_X0, 0);
            chk({px, py}, {pz(r1), 8'h00, r2[15:0]});
            acc = 0;
            cmd(OP_IMM, DST_HIGH, r3, 0);
            chk(aa[47:24], {8'h00, r3[7:0], 8'h00});
            cmd(OP_IMM, DST_LOW, r3, 0);
            chk(aa[23:0], {8'h00, r3[7:0], 8'h00});
            cmd(OP_IMM, DST_EXT, r3, 0);
            chk(aa[55:48], r3[7:0]);
            cmd(OP_IMM, DST_FULL, r3, 0);
            chk(aa[47:40], r3[7:0]);
            cmd(OP_IMM, DST_Y1, r3, 0);
            rd(OP_RDR, DST_Y1, 0);
            chk(px, {8'h00, r3[7:0], 8'h00});
        end
        $display("test done: moves and immediates");
        full(24'h400000, 8'h00, 2'h0, 24'h004000, 24'h000000, 0);
        full(24'hC00000, 8'hFF, 2'h0, 24'hFFC000, 24'h000000, 0);
        full(24'h400000, 8'h01, 2'h0, 24'h007FFF, 24'h00FFFF, 1);
        full(24'h800000, 8'hFE, 2'h0, 24'h008000, 24'h000000, 1);
        full(24'h400100, 8'h00, SCL_DOWN, 24'h002000, 24'h008000, 0);
        full(24'h400000, 8'h00, SCL_UP, 24'h007FFF, 24'h00FFFF, 1);
        $display("test done: scaling and limiting");
        cmd(OP_LOAD, DST_HIGH, 24'h000000, 0);
        bn = 5'h10;
        sub = BIT_SET;
        cmd(OP_BIT, DST_HIGH, 24'h000000, 0);
        chk({be, aa[47:24]}, {1'b1, 24'h0});
        bn = 5'h0F;
        cmd(OP_BIT, DST_HIGH, 24'h000000, 0);
        chk({be, aa[47:24]}, {1'b0, 24'h800000});
        sub = BIT_TST;
        cmd(OP_BIT, DST_HIGH, 24'h000000, 0);
        chk({br, be}, 2'b10);
        $display("test done: bit numbering");
        // Carry enters at the lower portion and ripples into the upper one.
        cmd(OP_LOAD, DST_FULL, 24'h100000, 0);
        cmd(OP_LOAD, DST_X1, 24'h000100, 0);
        cmd(OP_LOAD, DST_X0, 24'hFFFFAB, 0);
        cin = 1;
        cmd(OP_ADC, DST_FULL, 24'h000000, 0);
        chk(aa, 56'h00100200000000);
        cmd(OP_SBC, DST_FULL, 24'h000000, 0);
        chk(aa, 56'h00100000000000);
        cmd(OP_LOAD, DST_LOW, 24'h800000, 0);
        cmd(OP_RND, DST_FULL, 24'h000000, 0);
        chk(aa, 56'h00100100000000);
        cmd(OP_LOAD, DST_FULL, 24'h7FFF00, 0);
        sat = 1;
        cmd(OP_ADC, DST_FULL, 24'h000000, 0);
        chk(aa, SAT16_POS);
        sat = 0;
        cmd(OP_AND, DST_X1, 24'h000000, 0);
        chk(aa, 56'h00000100FFFF00);
        cmd(OP_LOAD, DST_HIGH, 24'h8001AB, 0);
        cin = 0;
        cmd(OP_ROL, DST_HIGH, 24'h000000, 0);
        chk({co, aa}, {1'b1, 56'h00000200FFFF00});
        // Dual MAC on accumulator B with the double-precision bit set.
        acc = 1;
        dpm = 1;
        cmd(OP_LOAD, DST_FULL, 24'h100000, 0);
        cmd(OP_LOAD, DST_X0, 24'h400000, 0);
        cmd(OP_LOAD, DST_Y0, 24'h400000, 0);
        cmd(OP_DUAL_MAC_OP, DST_X0, 24'h000000, 0);
        chk(ab, 56'h00200000100000);
        dpm = 0;
        acc = 0;
        $display("test done: arithmetic");
        m16 = 0;
        repeat (2) @(posedge clk_sys);
        cmd(OP_LOAD, DST_HIGH, r1, 0);
        rd(OP_RDP, DST_HIGH, 0);
        chk(px, r1);
        cmd(OP_LOAD, DST_X1, r2, 0);
        rd(OP_RDR, DST_X1, 0);
        chk(px, r2);
        cmd(OP_IMM, DST_HIGH, r3, 0);
        chk(aa[47:24], {16'h0000, r3[7:0]});
        $display("test done: normal mode");
        close_out();
    end
endmodule : tb_sbd_alu
